// [shared/cid_pkg.sv]
// shared constants and carrier types for the extended identifier buffer
package cid_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CID_OFS_TX_HIGH   = 8'h00;
  localparam logic [7:0] CID_OFS_TX_SECOND = 8'h04;
  localparam logic [7:0] CID_OFS_TX_THIRD  = 8'h08;
  localparam logic [7:0] CID_OFS_TX_LOW    = 8'h0C;
  localparam logic [7:0] CID_OFS_RX_HIGH   = 8'h10;
  localparam logic [7:0] CID_OFS_RX_SECOND = 8'h14;
  localparam logic [7:0] CID_OFS_RX_THIRD  = 8'h18;
  localparam logic [7:0] CID_OFS_RX_LOW    = 8'h1C;
  localparam logic [7:0] CID_OFS_CONTROL   = 8'h20;
  localparam logic [7:0] CID_OFS_STATUS    = 8'h24;
  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int CID_EXT_BITS  = 32;
  localparam int CID_STD_BITS  = 13;
  localparam int CID_EXT_ID_W  = 29;
  localparam int CID_STD_ID_W  = 11;
  localparam int CID_SRR_POS   = 4;
  localparam int CID_IDE_POS   = 3;
  localparam int CID_RTR_POS   = 0;
  localparam int CID_CTL_START = 0;
  localparam int CID_ST_BUSY   = 0;
  localparam int CID_ST_RXFULL = 1;
  localparam int CID_ST_WIN    = 2;
  localparam logic [5:0] CID_CNT_EXT = 6'h20;
  localparam logic [5:0] CID_CNT_STD = 6'h0D;
  localparam logic [1:0] CID_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CID_RESP_SLVERR = 2'h2;
  localparam logic [31:0] CID_ZERO32 = 32'h0000_0000;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } cid_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cid_axi_rsp_t;
endpackage

// [hw/cid_buffer.sv]
// extended identifier buffer: registers, arbitration shifter, receive capture
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cid_buffer
  import cid_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input  wire  logic         MCLK_IN,
  input  wire  logic         RST_N_IN,
  // register bus
  input  wire  cid_axi_req_t AXI_REQ_IN,
  output var   cid_axi_rsp_t AXI_RSP_OUT,
  // bus bit timing and arbitration
  input  wire  logic         TX_BIT_EN_IN,
  input  wire  logic [28:0]  RIVAL_ID_IN,
  output var   logic         TX_BIT_OUT,
  output var   logic         TX_BUSY_OUT,
  output var   logic         TX_WINS_OUT,
  // receive capture
  input  wire  logic         RX_STORE_IN,
  input  wire  logic [31:0]  RX_ID_IN
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0][7:0] tx_id;
    logic [3:0][7:0] rx_id;
    logic            rx_full;
    logic            busy;
    logic [31:0]     shreg;
    logic [5:0]      cnt;
    logic            tx_bit;
    logic            win;
    logic            aw_hold;
    logic [7:0]      aw_addr;
    logic            w_hold;
    logic [31:0]     wdata;
    logic            wlane;
    cid_axi_rsp_t    rsp;
  } cid_state_t;

  cid_state_t st_reg;
  cid_state_t st_next;

  if (ADDR_W != 8)
  begin : g_chk
    $error("cid_buffer: ADDR_W must be 8");
  end

  // ---------------------------------------------------------------
  // field decoding
  // ---------------------------------------------------------------
  // bytes concatenated high first already are the bus order
  function automatic logic [31:0] arb_field(input logic [3:0][7:0] b);
    logic [31:0] f;
    f = {b[3], b[2], b[1], b[0]};
    if (!b[2][CID_IDE_POS])
      f = {b[3], b[2][7:3], 19'h0_0000};
    return f;
  endfunction

  function automatic logic [28:0] id_value(input logic [3:0][7:0] b);
    logic [28:0] v;
    v = {b[3], b[2][7:5], b[2][2:0], b[1], b[0][7:1]};
    if (!b[2][CID_IDE_POS])
      v = {b[3], b[2][7:5], 18'h0_0000};
    return v;
  endfunction

  function automatic logic [31:0] rd_mux(input cid_state_t s, input logic [7:0] a, output logic ok);
    logic [31:0] d;
    d  = CID_ZERO32;
    ok = 1'b1;
    unique case (a)
      CID_OFS_TX_HIGH:   d[7:0] = s.tx_id[3];
      CID_OFS_TX_SECOND: d[7:0] = s.tx_id[2];
      CID_OFS_TX_THIRD:  d[7:0] = s.tx_id[1];
      CID_OFS_TX_LOW:    d[7:0] = s.tx_id[0];
      CID_OFS_RX_HIGH:   d[7:0] = s.rx_id[3];
      CID_OFS_RX_SECOND: d[7:0] = s.rx_id[2];
      CID_OFS_RX_THIRD:  d[7:0] = s.rx_id[1];
      CID_OFS_RX_LOW:    d[7:0] = s.rx_id[0];
      CID_OFS_CONTROL:   d = CID_ZERO32;
      CID_OFS_STATUS:
      begin
        d[CID_ST_BUSY]   = s.busy;
        d[CID_ST_RXFULL] = s.rx_full;
        d[CID_ST_WIN]    = s.win;
      end
      default:           ok = 1'b0;
    endcase
    return d;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic        rd_ok;
    logic        start;
    logic        rx_clr;
    logic [31:0] rdat;
    st_next = st_reg;
    rd_ok   = 1'b0;
    start   = 1'b0;
    rx_clr  = 1'b0;
    rdat    = CID_ZERO32;

    // write address and data, taken in either order
    if (AXI_REQ_IN.awvalid && st_reg.rsp.awready)
    begin
      st_next.aw_hold = 1'b1;
      st_next.aw_addr = AXI_REQ_IN.awaddr;
    end
    if (AXI_REQ_IN.wvalid && st_reg.rsp.wready)
    begin
      st_next.w_hold = 1'b1;
      st_next.wdata  = AXI_REQ_IN.wdata;
      st_next.wlane  = AXI_REQ_IN.wstrb[0];
    end
    if (st_reg.aw_hold && st_reg.w_hold && !st_reg.rsp.bvalid)
    begin
      st_next.aw_hold    = 1'b0;
      st_next.w_hold     = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp  = CID_RESP_OKAY;
      unique case (st_reg.aw_addr)
        CID_OFS_TX_HIGH:   if (st_reg.wlane) st_next.tx_id[3] = st_reg.wdata[7:0];
        CID_OFS_TX_SECOND: if (st_reg.wlane) st_next.tx_id[2] = st_reg.wdata[7:0];
        CID_OFS_TX_THIRD:  if (st_reg.wlane) st_next.tx_id[1] = st_reg.wdata[7:0];
        CID_OFS_TX_LOW:    if (st_reg.wlane) st_next.tx_id[0] = st_reg.wdata[7:0];
        CID_OFS_CONTROL:   start = st_reg.wlane && st_reg.wdata[CID_CTL_START];
        CID_OFS_STATUS:    rx_clr = st_reg.wlane && st_reg.wdata[CID_ST_RXFULL];
        CID_OFS_RX_HIGH, CID_OFS_RX_SECOND, CID_OFS_RX_THIRD, CID_OFS_RX_LOW: ;
        default:           st_next.rsp.bresp = CID_RESP_SLVERR;
      endcase
    end
    if (st_reg.rsp.bvalid && AXI_REQ_IN.bready)
      st_next.rsp.bvalid = 1'b0;
    st_next.rsp.awready = !st_next.aw_hold && !st_next.rsp.bvalid;
    st_next.rsp.wready  = !st_next.w_hold && !st_next.rsp.bvalid;

    // read channel: one cycle from address to data
    if (AXI_REQ_IN.arvalid && st_reg.rsp.arready)
    begin
      rdat               = rd_mux(st_reg, AXI_REQ_IN.araddr, rd_ok);
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rdata  = rdat;
      st_next.rsp.rresp  = rd_ok ? CID_RESP_OKAY : CID_RESP_SLVERR;
    end
    else if (st_reg.rsp.rvalid && AXI_REQ_IN.rready)
      st_next.rsp.rvalid = 1'b0;
    st_next.rsp.arready = !st_next.rsp.rvalid;

    // arbitration field shifter, msb first
    if (start && !st_reg.busy)
    begin
      st_next.busy  = 1'b1;
      st_next.shreg = arb_field(st_next.tx_id);
      st_next.cnt   = st_next.tx_id[2][CID_IDE_POS] ? CID_CNT_EXT : CID_CNT_STD;
    end
    else if (st_reg.busy && TX_BIT_EN_IN)
    begin
      st_next.tx_bit = st_reg.shreg[31];
      st_next.shreg  = {st_reg.shreg[30:0], 1'b1};
      st_next.cnt    = st_reg.cnt - 6'h01;
      st_next.busy   = (st_reg.cnt != 6'h01);
    end
    // the last field bit stands one clock before the line goes recessive
    if (!st_reg.busy)
      st_next.tx_bit = 1'b1;

    // lower identifier wins
    st_next.win = id_value(st_reg.tx_id) < RIVAL_ID_IN;

    // receive capture; a new frame wins over a software clear
    if (rx_clr)
      st_next.rx_full = 1'b0;
    if (RX_STORE_IN)
    begin
      st_next.rx_id   = RX_ID_IN;
      st_next.rx_full = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // identifier bytes are left unreset, like the buffer ram
  always_ff @(posedge MCLK_IN)
  begin
    st_reg <= st_next;
    if (!RST_N_IN)
    begin
      st_reg.rx_full <= 1'b0;
      st_reg.busy    <= 1'b0;
      st_reg.shreg   <= CID_ZERO32;
      st_reg.cnt     <= 6'h00;
      st_reg.tx_bit  <= 1'b1;
      st_reg.win     <= 1'b0;
      st_reg.aw_hold <= 1'b0;
      st_reg.aw_addr <= 8'h00;
      st_reg.w_hold  <= 1'b0;
      st_reg.wdata   <= CID_ZERO32;
      st_reg.wlane   <= 1'b0;
      st_reg.rsp     <= '0;
    end
  end

  assign AXI_RSP_OUT = st_reg.rsp;
  assign TX_BIT_OUT  = st_reg.tx_bit;
  assign TX_BUSY_OUT = st_reg.busy;
  assign TX_WINS_OUT = st_reg.win;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_rx_capture: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    RX_STORE_IN |=> st_reg.rx_id == $past(RX_ID_IN))
    else $error("received identifier not stored as sampled");

  chk_rx_flags: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    RX_STORE_IN |=> st_reg.rx_id[2][CID_IDE_POS] == $past(RX_ID_IN[19]) && st_reg.rx_full)
    else $error("received format flag lost");

  chk_rx_rtr: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    RX_STORE_IN |=> st_reg.rx_id[0][CID_RTR_POS] == $past(RX_ID_IN[0]))
    else $error("received remote flag lost");

  chk_ext_count: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    $rose(st_reg.busy) && st_reg.tx_id[2][CID_IDE_POS] |-> st_reg.cnt == CID_CNT_EXT)
    else $error("extended field not 32 bits");

  chk_std_count: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    $rose(st_reg.busy) && !st_reg.tx_id[2][CID_IDE_POS] |-> st_reg.cnt == CID_CNT_STD)
    else $error("standard field not 13 bits");

  chk_msb_first: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.busy && TX_BIT_EN_IN && st_reg.cnt == (st_reg.tx_id[2][CID_IDE_POS] ? CID_CNT_EXT : CID_CNT_STD)
      |=> TX_BIT_OUT == $past(st_reg.tx_id[3][7]))
    else $error("identifier msb not sent first");

  chk_bit_order: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.busy && TX_BIT_EN_IN |=> TX_BIT_OUT == $past(st_reg.shreg[31]))
    else $error("arbitration bits out of order");

  chk_std_ignore: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    $rose(st_reg.busy) && !st_reg.tx_id[2][CID_IDE_POS] |-> st_reg.shreg[18:0] == 19'h0_0000)
    else $error("extended bits leak into standard frame");

  chk_priority: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.tx_id[2][CID_IDE_POS] && $stable(st_reg.tx_id) ##1 $stable(st_reg.tx_id)
      |-> TX_WINS_OUT == (id_value(st_reg.tx_id) < $past(RIVAL_ID_IN)))
    else $error("smaller identifier did not win");

  chk_read_one: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    AXI_REQ_IN.arvalid && AXI_RSP_OUT.arready |=> AXI_RSP_OUT.rvalid && !AXI_RSP_OUT.arready)
    else $error("read not answered in one cycle");

  chk_write_resp: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.aw_hold && st_reg.w_hold && !AXI_RSP_OUT.bvalid |=> AXI_RSP_OUT.bvalid)
    else $error("write response missing");

  chk_rx_srr: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    RX_STORE_IN |=> st_reg.rx_id[2][CID_SRR_POS] == $past(RX_ID_IN[20]))
    else $error("received substitute bit altered");

  chk_rx_clear: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.aw_hold && st_reg.w_hold && !AXI_RSP_OUT.bvalid && st_reg.wlane && st_reg.aw_addr == CID_OFS_STATUS
      && st_reg.wdata[CID_ST_RXFULL] && !RX_STORE_IN |=> !st_reg.rx_full)
    else $error("receive full flag not cleared");

  chk_wr_high: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.aw_hold && st_reg.w_hold && !AXI_RSP_OUT.bvalid && st_reg.wlane && st_reg.aw_addr == CID_OFS_TX_HIGH
      |=> st_reg.tx_id[3] == $past(st_reg.wdata[7:0]))
    else $error("high identifier byte not written");

  chk_wr_second: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.aw_hold && st_reg.w_hold && !AXI_RSP_OUT.bvalid && st_reg.wlane && st_reg.aw_addr == CID_OFS_TX_SECOND
      |=> st_reg.tx_id[2] == $past(st_reg.wdata[7:0]))
    else $error("second identifier byte not written");

  chk_wr_third: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.aw_hold && st_reg.w_hold && !AXI_RSP_OUT.bvalid && st_reg.wlane && st_reg.aw_addr == CID_OFS_TX_THIRD
      |=> st_reg.tx_id[1] == $past(st_reg.wdata[7:0]))
    else $error("third identifier byte not written");

  chk_wr_low: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.aw_hold && st_reg.w_hold && !AXI_RSP_OUT.bvalid && st_reg.wlane && st_reg.aw_addr == CID_OFS_TX_LOW
      |=> st_reg.tx_id[0] == $past(st_reg.wdata[7:0]))
    else $error("low identifier byte not written");

  chk_bresp_hold: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    AXI_RSP_OUT.bvalid && !AXI_REQ_IN.bready |=> AXI_RSP_OUT.bvalid && $stable(AXI_RSP_OUT.bresp))
    else $error("write response dropped before taken");

  chk_rdata_hold: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    AXI_RSP_OUT.rvalid && !AXI_REQ_IN.rready |=> AXI_RSP_OUT.rvalid && $stable(AXI_RSP_OUT.rdata))
    else $error("read data dropped before taken");

  chk_last_bit: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.busy && TX_BIT_EN_IN && st_reg.cnt == 6'h01 |=> !TX_BUSY_OUT && TX_BIT_OUT == $past(st_reg.shreg[31]))
    else $error("last field bit not shown");

  chk_idle_bit: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    !TX_BUSY_OUT && !$past(TX_BUSY_OUT) |-> TX_BIT_OUT)
    else $error("idle line not recessive");

  chk_bit_hold: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.busy && !TX_BIT_EN_IN |=> $stable(TX_BIT_OUT) && $stable(st_reg.cnt))
    else $error("field bit moved without a bit pulse");

  chk_rd_high: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    AXI_REQ_IN.arvalid && AXI_RSP_OUT.arready && AXI_REQ_IN.araddr == CID_OFS_TX_HIGH
      |=> AXI_RSP_OUT.rdata == {24'h00_0000, $past(st_reg.tx_id[3])})
    else $error("high identifier byte read back wrong");

  chk_rd_unmapped: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    AXI_REQ_IN.arvalid && AXI_RSP_OUT.arready && AXI_REQ_IN.araddr > CID_OFS_STATUS
      |=> AXI_RSP_OUT.rresp == CID_RESP_SLVERR && AXI_RSP_OUT.rdata == CID_ZERO32)
    else $error("unmapped read not refused");

  chk_busy_count: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.busy |-> st_reg.cnt != 6'h00)
    else $error("shifter busy with no bits left");
endmodule
`default_nettype wire

// [verif/cid_bus_node.sv]
// far-side node model: bit timing pulses, rival identifier, received frames
`timescale 1ns/1ps
`default_nettype none
module cid_bus_node
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // bit timing control
  input  wire logic        run_in,
  input  wire logic [3:0]  gap_in,
  // towards the buffer
  output var  logic        bit_en_out,
  output var  logic [28:0] rival_out,
  output var  logic        rx_store_out,
  output var  logic [31:0] rx_id_out
);
  logic [3:0] cnt_reg;
  initial
  begin
    rival_out = 29'h0;
    rx_store_out = 1'b0;
    rx_id_out = 32'h0;
  end
  // bit time stands still outside frames
  always @(posedge clk_in)
  begin
    cnt_reg <= (!rst_n_in || !run_in || cnt_reg == gap_in) ? 4'h0 : cnt_reg + 4'h1;
    bit_en_out <= rst_n_in && run_in && cnt_reg == gap_in;
  end
  task automatic set_rival(input logic [28:0] v);
    rival_out <= v;
  endtask
  // one stored frame, then the lines stop showing it
  task automatic rx_frame(input logic [31:0] v);
    rx_id_out <= v;
    rx_store_out <= 1'b1;
    @(posedge clk_in);
    rx_store_out <= 1'b0;
    rx_id_out <= ~v;
  endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the extended identifier buffer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cid_pkg::*;
  logic         clk;
  logic         rst_n;
  cid_axi_req_t req;
  cid_axi_rsp_t rsp;
  logic         run;
  logic [3:0]   gap;
  logic         ben;
  logic         txb;
  logic         busy;
  logic         wins;
  logic         rxs;
  logic [28:0]  rival;
  logic [31:0]  rxid;
  logic [31:0]  d;
  logic [31:0]  f;
  logic [31:0]  ef;
  logic [1:0]   r;
  logic [28:0]  id;
  logic [10:0]  sid;
  int           err_total;
  int           cmp_count;
  cid_buffer #(.ADDR_W(8)) dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .AXI_REQ_IN(req), .AXI_RSP_OUT(rsp),
    .TX_BIT_EN_IN(ben), .RIVAL_ID_IN(rival), .TX_BIT_OUT(txb), .TX_BUSY_OUT(busy), .TX_WINS_OUT(wins),
    .RX_STORE_IN(rxs), .RX_ID_IN(rxid));
  cid_bus_node node (.clk_in(clk), .rst_n_in(rst_n), .run_in(run), .gap_in(gap), .bit_en_out(ben),
    .rival_out(rival), .rx_store_out(rxs), .rx_id_out(rxid));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo(input string nm);
    err_total++;
    $display("ERROR %s wait expired", nm);
    test_done();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // ---------------------------------------------------------------
  // register bus master
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    rs = rsp.bresp;
    if (n == 60) tmo("write");
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    d = rsp.rdata;
    r = rsp.rresp;
    if (n == 60) tmo("read");
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  // start a shift and gather nb field bits, one after each bit pulse
  task automatic shift(input int nb, input logic [3:0] g);
    int n;
    int k;
    logic p;
    f = 32'h0;
    k = 0;
    p = 1'b0;
    wr(CID_OFS_CONTROL, 32'h0000_0001, r);
    chk("busy at start", 32'h1, {31'h0, busy});
    gap <= g;
    run <= 1'b1;
    for (n = 0; n < 600 && k < nb; n++)
    begin
      @(posedge clk);
      if (p) f = {f[30:0], txb};
      if (p) k++;
      p = ben;
    end
    run <= 1'b0;
    if (k < nb) tmo("shift");
    chk("busy at end", 32'h0, {31'h0, busy});
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    err_total = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    req = '0;
    run = 1'b0;
    gap = 4'h2;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("idle bit", 32'h1, {31'h0, txb});
    chk("idle busy", 32'h0, {31'h0, busy});
    id = 29'h1A5C_3E96;
    ef = {id[28:18], 2'b11, id[17:0], 1'b1};
    for (int i = 0; i < 4; i++) wr(CID_OFS_TX_HIGH + 8'(4 * i), {24'h0, ef[31 - 8 * i -: 8]}, r);
    for (int i = 0; i < 4; i++) rchk(CID_OFS_TX_HIGH + 8'(4 * i), {24'h0, ef[31 - 8 * i -: 8]}, CID_RESP_OKAY);
    shift(32, 4'h4);
    chk("ext field", ef, f);
    for (int i = 0; i < 3; i++)
    begin
      node.set_rival(id + 29'(i) - 29'h1);
      repeat (3) @(posedge clk);
      chk("wins", {31'h0, i == 2}, {31'h0, wins});
      rchk(CID_OFS_STATUS, {29'h0, i == 2, 2'b00}, CID_RESP_OKAY);
    end
    sid = 11'h5A3;
    wr(CID_OFS_TX_HIGH, {24'h0, sid[10:3]}, r);
    wr(CID_OFS_TX_SECOND, {24'h0, sid[2:0], 2'b00, 3'b111}, r);
    shift(13, 4'h2);
    chk("std field", {19'h0, sid, 2'b00}, f);
    node.set_rival(29'h0);
    for (int j = 0; j < 2; j++)
    begin
      ef = j ? 32'hC3B0_E1F0 : 32'h5A6F_0F0F;
      node.rx_frame(ef);
      for (int i = 0; i < 4; i++) rchk(CID_OFS_RX_HIGH + 8'(4 * i), {24'h0, ef[31 - 8 * i -: 8]}, CID_RESP_OKAY);
    end
    rchk(CID_OFS_STATUS, 32'h0000_0002, CID_RESP_OKAY);
    wr(CID_OFS_STATUS, 32'h0000_0002, r);
    rchk(CID_OFS_STATUS, 32'h0000_0000, CID_RESP_OKAY);
    wr(CID_OFS_RX_HIGH, 32'h0000_0011, r);
    chk("rx write bresp", {30'h0, CID_RESP_OKAY}, {30'h0, r});
    rchk(CID_OFS_RX_HIGH, 32'h0000_00C3, CID_RESP_OKAY);
    wr(8'h28, 32'h0000_0055, r);
    chk("unmapped bresp", {30'h0, CID_RESP_SLVERR}, {30'h0, r});
    rchk(8'h28, 32'h0000_0000, CID_RESP_SLVERR);
    test_done();
  end
endmodule
`default_nettype wire
